// file: hdl/i2css_regs.vh
`ifndef I2CSS_REGS_VH
`define I2CSS_REGS_VH
// register byte offsets
`define I2CSS_OFS_ADDR 4'h0
`define I2CSS_OFS_CTRL 4'h4
`define I2CSS_OFS_STAT 4'h8
`define I2CSS_OFS_DATA 4'hC
// serial_control field positions
`define I2CSS_CB_FLAG 7
`define I2CSS_CB_ACKEN 6
`define I2CSS_CB_STA 5
`define I2CSS_CB_STO 4
`define I2CSS_CB_WCOL 3
`define I2CSS_CB_EN 2
`define I2CSS_CB_IE 0
// reset values
`define I2CSS_RST_ADDR 8'h00
`define I2CSS_RST_CODE 8'hF8
`define I2CSS_RST_TX 8'hFF
// status codes, prescaler bits zero
`define I2CSS_SC_SRW 8'h60
`define I2CSS_SC_ARBW 8'h68
`define I2CSS_SC_GCW 8'h70
`define I2CSS_SC_ARBGC 8'h78
`define I2CSS_SC_RXACK 8'h80
`define I2CSS_SC_RXNAK 8'h88
`define I2CSS_SC_GCACK 8'h90
`define I2CSS_SC_GCNAK 8'h98
`define I2CSS_SC_STOP 8'hA0
`define I2CSS_SC_SRR 8'hA8
`define I2CSS_SC_ARBR 8'hB0
`define I2CSS_SC_TXACK 8'hB8
`define I2CSS_SC_TXNAK 8'hC0
`define I2CSS_SC_TXLST 8'hC8
// general call address
`define I2CSS_GC_ADDR 7'h00
`endif

// file: hdl/i2css_engine.v
`timescale 1ns/1ns
`include "i2css_regs.vh"

module i2css_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire core_clk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   wire do_push = in_valid & in_ready;
   wire do_pop = out_valid & out_ready;
   assign in_ready = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data = mem_ff[rd_ptr_ff];
   always @(posedge core_clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (do_push & ~do_pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_pop & ~do_push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // i2css_fifo

module i2css_top #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire core_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_n,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_n,
   input wire deep_sleep,
   input wire arb_lost,
   output reg wake_request,
   output reg start_issue
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_AACK = 3'd2;
   localparam ST_WAIT = 3'd3;
   localparam ST_RX = 3'd4;
   localparam ST_RACK = 3'd5;
   localparam ST_TX = 3'd6;
   localparam ST_TACK = 3'd7;

   reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
   reg sda_s1_ff, sda_s2_ff, sda_s3_ff;
   reg [7:0] own_slave_address_ff;
   reg step_done_flag_ff, ack_enable_ff, start_request_ff, stop_request_ff;
   reg write_collision_flag_ff, interface_enable_ff, interrupt_enable_ff;
   reg [1:0] presc_ff;
   reg [7:0] serial_status_code_ff, nxt_code;
   reg [7:0] tx_byte_ff;
   reg [2:0] state_ff, nxt_state, tgt_ff, nxt_tgt;
   reg [3:0] cnt_ff, nxt_cnt;
   reg [7:0] shift_ff, nxt_shift;
   reg gc_ff, nxt_gc, dir_rd_ff, nxt_dir_rd, last_ff, nxt_last, mack_ff, nxt_mack;
   reg addressed_ff, nxt_addressed, slept_ff, nxt_slept;
   reg nxt_sda_drv, nxt_scl_hold, set_flag, push, nxt_wake;
   reg start_pend_ff, nxt_pend, bus_free_ff;
   wire [7:0] rx_head;
   wire rx_valid, rx_ready;

   wire scl_rise = scl_s2_ff & ~scl_s3_ff;
   wire scl_fall = ~scl_s2_ff & scl_s3_ff;
   wire bus_start = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
   wire bus_stop = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   wire wb_rd = wb_req & ~wb_we_i;
   wire ctrl_wr = wb_wr & (wb_adr_i == `I2CSS_OFS_CTRL);
   wire data_wr = wb_wr & (wb_adr_i == `I2CSS_OFS_DATA);
   wire data_rd = wb_rd & (wb_adr_i == `I2CSS_OFS_DATA);
   wire flag_clr = ctrl_wr & wb_dat_i[`I2CSS_CB_FLAG];
   wire [6:0] rx_addr = shift_ff[7:1];
   wire own_hit = (rx_addr == own_slave_address_ff[7:1]);
   wire gc_hit = (rx_addr == `I2CSS_GC_ADDR) & own_slave_address_ff[0];

   function [7:0] pick;
      input sel;
      input [7:0] code_a;
      input [7:0] code_b;
      begin
         pick = sel ? code_a : code_b;
      end
   endfunction

   i2css_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_data(shift_ff),
      .in_valid(push),
      .in_ready(rx_ready),
      .out_data(rx_head),
      .out_valid(rx_valid),
      .out_ready(data_rd)
   );

   always @* begin
      nxt_state = state_ff;
      nxt_tgt = tgt_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_gc = gc_ff;
      nxt_dir_rd = dir_rd_ff;
      nxt_last = last_ff;
      nxt_mack = mack_ff;
      nxt_addressed = addressed_ff;
      nxt_slept = slept_ff;
      nxt_code = serial_status_code_ff;
      nxt_sda_drv = ~sda_oe_n;
      nxt_scl_hold = 1'b0;
      nxt_wake = 1'b0;
      set_flag = 1'b0;
      push = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_sda_drv = 1'b0;
         end
         ST_ADDR: begin
            if (scl_rise) begin
               nxt_shift = {shift_ff[6:0], sda_s2_ff};
               nxt_cnt = cnt_ff + 4'd1;
            end else if (scl_fall && cnt_ff == 4'd8) begin
               if (ack_enable_ff && (own_hit || gc_hit)) begin
                  nxt_state = ST_AACK;
                  nxt_sda_drv = 1'b1;
                  nxt_gc = ~own_hit;
                  nxt_dir_rd = shift_ff[0];
                  nxt_slept = deep_sleep;
                  nxt_wake = deep_sleep;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_AACK: begin
            if (scl_fall) begin
               nxt_sda_drv = 1'b0;
               set_flag = 1'b1;
               nxt_addressed = 1'b1;
               nxt_cnt = 4'd0;
               nxt_state = ST_WAIT;
               nxt_scl_hold = 1'b1;
               if (dir_rd_ff) begin
                  nxt_tgt = ST_TX;
                  nxt_code = pick(arb_lost, `I2CSS_SC_ARBR, `I2CSS_SC_SRR);
               end else if (gc_ff) begin
                  nxt_tgt = ST_RX;
                  nxt_code = pick(arb_lost, `I2CSS_SC_ARBGC, `I2CSS_SC_GCW);
               end else begin
                  nxt_tgt = ST_RX;
                  nxt_code = pick(arb_lost, `I2CSS_SC_ARBW, `I2CSS_SC_SRW);
               end
            end
         end
         ST_WAIT: begin
            nxt_scl_hold = step_done_flag_ff & ~flag_clr;
            if (!nxt_scl_hold) begin
               nxt_slept = 1'b0;
               nxt_cnt = 4'd0;
               nxt_state = tgt_ff;
               if (tgt_ff == ST_TX) begin
                  nxt_shift = tx_byte_ff;
                  nxt_last = ~ack_enable_ff;
                  nxt_sda_drv = ~tx_byte_ff[7];
               end
            end
         end
         ST_RX: begin
            if (scl_rise) begin
               nxt_shift = {shift_ff[6:0], sda_s2_ff};
               nxt_cnt = cnt_ff + 4'd1;
            end else if (cnt_ff == 4'd8 && ~scl_s2_ff) begin
               if (!rx_ready && ack_enable_ff && !slept_ff) begin
                  nxt_scl_hold = 1'b1;
               end else begin
                  nxt_mack = ack_enable_ff;
                  nxt_sda_drv = ack_enable_ff;
                  push = ack_enable_ff & ~slept_ff;
                  nxt_cnt = 4'd0;
                  nxt_state = ST_RACK;
               end
            end
         end
         ST_RACK: begin
            if (scl_fall) begin
               nxt_sda_drv = 1'b0;
               set_flag = 1'b1;
               nxt_scl_hold = 1'b1;
               nxt_state = ST_WAIT;
               nxt_tgt = mack_ff ? ST_RX : ST_IDLE;
               nxt_addressed = mack_ff;
               if (gc_ff) begin
                  nxt_code = pick(mack_ff, `I2CSS_SC_GCACK, `I2CSS_SC_GCNAK);
               end else begin
                  nxt_code = pick(mack_ff, `I2CSS_SC_RXACK, `I2CSS_SC_RXNAK);
               end
            end
         end
         ST_TX: begin
            // ack enable dropped at or after the flag clear makes this byte the last
            nxt_last = last_ff | ~ack_enable_ff;
            if (scl_fall) begin
               nxt_cnt = cnt_ff + 4'd1;
               nxt_shift = {shift_ff[6:0], 1'b1};
               nxt_sda_drv = ~shift_ff[6];
               if (cnt_ff == 4'd7) begin
                  nxt_sda_drv = 1'b0;
                  nxt_state = ST_TACK;
               end
            end
         end
         ST_TACK: begin
            if (scl_rise) begin
               nxt_mack = ~sda_s2_ff;
            end else if (scl_fall) begin
               set_flag = 1'b1;
               nxt_scl_hold = 1'b1;
               nxt_state = ST_WAIT;
               nxt_cnt = 4'd0;
               if (!mack_ff) begin
                  nxt_code = `I2CSS_SC_TXNAK;
               end else begin
                  nxt_code = pick(last_ff, `I2CSS_SC_TXLST, `I2CSS_SC_TXACK);
               end
               nxt_addressed = mack_ff & ~last_ff;
               nxt_tgt = (mack_ff & ~last_ff) ? ST_TX : ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (bus_start || bus_stop) begin
         nxt_sda_drv = 1'b0;
         nxt_scl_hold = 1'b0;
         nxt_cnt = 4'd0;
         nxt_state = bus_start ? ST_ADDR : ST_IDLE;
         if (addressed_ff) begin
            nxt_code = `I2CSS_SC_STOP;
            set_flag = 1'b1;
            nxt_addressed = 1'b0;
         end
      end
      if (!interface_enable_ff) begin
         nxt_state = ST_IDLE;
         nxt_addressed = 1'b0;
         nxt_sda_drv = 1'b0;
         nxt_scl_hold = 1'b0;
      end
      nxt_pend = start_pend_ff;
      if (set_flag && !nxt_addressed && start_request_ff) begin
         nxt_pend = 1'b1;
      end else if (start_issue) begin
         nxt_pend = 1'b0;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_s3_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
         state_ff <= ST_IDLE;
         tgt_ff <= ST_IDLE;
         cnt_ff <= 4'd0;
         shift_ff <= 8'h00;
         gc_ff <= 1'b0;
         dir_rd_ff <= 1'b0;
         last_ff <= 1'b0;
         mack_ff <= 1'b0;
         addressed_ff <= 1'b0;
         slept_ff <= 1'b0;
         serial_status_code_ff <= `I2CSS_RST_CODE;
         start_pend_ff <= 1'b0;
         bus_free_ff <= 1'b1;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         wake_request <= 1'b0;
         start_issue <= 1'b0;
      end else begin
         scl_s1_ff <= scl_i;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
         state_ff <= nxt_state;
         tgt_ff <= nxt_tgt;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         gc_ff <= nxt_gc;
         dir_rd_ff <= nxt_dir_rd;
         last_ff <= nxt_last;
         mack_ff <= nxt_mack;
         addressed_ff <= nxt_addressed;
         slept_ff <= nxt_slept;
         serial_status_code_ff <= nxt_code;
         start_pend_ff <= nxt_pend;
         if (bus_start) begin
            bus_free_ff <= 1'b0;
         end else if (bus_stop) begin
            bus_free_ff <= 1'b1;
         end
         scl_oe_n <= ~nxt_scl_hold;
         sda_oe_n <= ~nxt_sda_drv;
         wake_request <= nxt_wake;
         start_issue <= start_pend_ff & bus_free_ff & ~start_issue;
      end
   end

   // register file and wishbone slave
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         own_slave_address_ff <= `I2CSS_RST_ADDR;
         step_done_flag_ff <= 1'b0;
         ack_enable_ff <= 1'b0;
         start_request_ff <= 1'b0;
         stop_request_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         interface_enable_ff <= 1'b0;
         interrupt_enable_ff <= 1'b0;
         presc_ff <= 2'b00;
         tx_byte_ff <= `I2CSS_RST_TX;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_wr && wb_adr_i == `I2CSS_OFS_ADDR) begin
            own_slave_address_ff <= wb_dat_i[7:0];
         end
         if (wb_wr && wb_adr_i == `I2CSS_OFS_STAT) begin
            presc_ff <= wb_dat_i[1:0];
         end
         // set wins over a clear in the same cycle
         step_done_flag_ff <= set_flag | (step_done_flag_ff & ~flag_clr);
         if (ctrl_wr) begin
            ack_enable_ff <= wb_dat_i[`I2CSS_CB_ACKEN];
            stop_request_ff <= wb_dat_i[`I2CSS_CB_STO];
            interface_enable_ff <= wb_dat_i[`I2CSS_CB_EN];
            interrupt_enable_ff <= wb_dat_i[`I2CSS_CB_IE];
         end
         if (start_issue) begin
            start_request_ff <= 1'b0;
         end else if (ctrl_wr) begin
            start_request_ff <= wb_dat_i[`I2CSS_CB_STA];
         end
         if (data_wr) begin
            if (step_done_flag_ff) begin
               tx_byte_ff <= wb_dat_i[7:0];
               write_collision_flag_ff <= 1'b0;
            end else begin
               write_collision_flag_ff <= 1'b1;
            end
         end
         if (wb_rd) begin
            case (wb_adr_i)
               `I2CSS_OFS_ADDR: wb_dat_o <= {24'h000000, own_slave_address_ff};
               `I2CSS_OFS_CTRL: wb_dat_o <= {24'h000000, step_done_flag_ff, ack_enable_ff,
                  start_request_ff, stop_request_ff, write_collision_flag_ff,
                  interface_enable_ff, 1'b0, interrupt_enable_ff};
               `I2CSS_OFS_STAT: wb_dat_o <= {24'h000000, serial_status_code_ff[7:3], 1'b0,
                  presc_ff};
               `I2CSS_OFS_DATA: wb_dat_o <= {24'h000000, rx_valid ? rx_head : 8'hFF};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // i2css_top

// file: testbench/i2css_master_model.sv
`timescale 1ns/1ns
module i2css_master_model (
   input wire core_clk,
   input wire scl_line,
   input wire sda_line,
   output logic scl_m,
   output logic sda_m,
   output logic hung
);
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      hung = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // release scl, then wait out any stretch by the slave, bounded
   task automatic rise;
      int i;
      scl_m <= 1'b1;
      i = 0;
      do begin cyc(1); i++; end while (scl_line !== 1'b1 && i < 4000);
      if (i >= 4000) hung <= 1'b1;
      cyc(3);
   endtask
   task automatic start;
      cyc(1);
      sda_m <= 1'b1;
      cyc(3);
      rise;
      sda_m <= 1'b0;
      cyc(4);
      scl_m <= 1'b0;
   endtask
   // nine clocks msb first; bit 0 is the acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int k = 8; k >= 0; k--) begin
         cyc(1);
         sda_m <= tx[k];
         cyc(3);
         rise;
         rx[k] = sda_line;
         scl_m <= 1'b0;
      end
      cyc(1);
      sda_m <= 1'b1;
      cyc(8);
   endtask
   task automatic stop;
      cyc(1);
      sda_m <= 1'b0;
      cyc(3);
      rise;
      sda_m <= 1'b1;
      cyc(8);
   endtask
endmodule // i2css_master_model

// file: testbench/i2css_top_assertions.sv
`timescale 1ns/1ns
`include "i2css_regs.vh"
module i2css_chk #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire core_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire scl_i,
   input wire scl_o,
   input wire scl_oe_n,
   input wire sda_i,
   input wire sda_o,
   input wire sda_oe_n,
   input wire deep_sleep,
   input wire arb_lost,
   input wire wake_request,
   input wire start_issue
);
   logic en_ff;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         en_ff <= 1'b0;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
            && wb_adr_i == `I2CSS_OFS_CTRL) begin
         en_ff <= wb_dat_i[`I2CSS_CB_EN];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus request not acked");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_rd_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
   property p_off_quiet; !en_ff |=> sda_oe_n && scl_oe_n; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("lines driven while off");
   property p_rel_sw;
      $rose(scl_oe_n) |-> $past(wb_stb_i, 1) || $past(wb_stb_i, 2) || $past(wb_stb_i, 3);
   endproperty
   a_rel_sw: assert property (p_rel_sw) else $error("clock released without access");
   property p_wake_sleep; wake_request |-> $past(deep_sleep); endproperty
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
   property p_wake_hold; wake_request |-> ##[0:8] !scl_oe_n; endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("clock not held on wake");
   property p_start_pulse; start_issue |=> !start_issue; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_start_free; start_issue |-> scl_i && sda_i; endproperty
   a_start_free: assert property (p_start_free) else $error("start while bus busy");
   property p_open_drain; !scl_o && !sda_o; endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   c_wake: cover property (wake_request);
   c_start: cover property (start_issue);
   c_stretch: cover property ($fell(scl_oe_n));
   c_write: cover property (wb_ack_o && wb_we_i);
endmodule // i2css_chk
bind i2css_top i2css_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_u (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
   .deep_sleep(deep_sleep), .arb_lost(arb_lost), .wake_request(wake_request),
   .start_issue(start_issue));

// file: testbench/tb_i2c_slave_mode_engine.sv
`timescale 1ns/1ns
`include "i2css_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_i2c_slave_mode_engine;
   logic core_clk, rst, cyc, stb, we, deep_sleep, arb_lost;
   logic [3:0] adr;
   logic [31:0] wdat, rv;
   logic [8:0] rx;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, scl_o, scl_oe_n, sda_o, sda_oe_n, wake_request, start_issue;
   wire scl_m, sda_m, hung;
   wire scl_line = scl_m & (scl_oe_n | scl_o);
   wire sda_line = sda_m & (sda_oe_n | sda_o);
   int failures = 0, n_checks = 0, n_wake = 0, n_start = 0;
   i2css_top #(.FIFO_DEPTH(8), .FIFO_AW(3)) dut_u (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .deep_sleep(deep_sleep),
      .arb_lost(arb_lost), .wake_request(wake_request), .start_issue(start_issue));
   i2css_master_model m_u (.core_clk(core_clk), .scl_line(scl_line), .sda_line(sda_line),
      .scl_m(scl_m), .sda_m(sda_m), .hung(hung));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (wake_request === 1'b1) n_wake++;
      if (start_issue === 1'b1) n_start++;
      if (hung === 1'b1) begin
         failures++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int i;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      i = 0;
      do begin @(posedge core_clk); i++; end while (wb_ack_o !== 1'b1 && i < 20);
      rv = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         failures++;
         close_out;
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      `CHK(rv, {24'h000000, e})
   endtask
   // poll until the step flag rises, then compare the masked status
   task automatic flag(input logic [7:0] code);
      int i;
      i = 0;
      do begin wb(1'b0, `I2CSS_OFS_CTRL, 8'h00); i++; end while (rv[7] !== 1'b1 && i < 300);
      if (i >= 300) begin
         failures++;
         close_out;
      end
      wb(1'b0, `I2CSS_OFS_STAT, 8'h00);
      `CHK(rv[7:0] & 8'hF8, code)
      if (code != `I2CSS_SC_STOP) `CHK(scl_oe_n, 1'b0)
   endtask
   task automatic clr(input logic [7:0] c);
      wb(1'b1, `I2CSS_OFS_CTRL, c);
   endtask
   task automatic send(input logic [7:0] b, input logic nak);
      m_u.xfer({b, 1'b1}, rx);
      `CHK(rx[0], nak)
   endtask
   task automatic t_reset;
      rdchk(`I2CSS_OFS_ADDR, `I2CSS_RST_ADDR);
      rdchk(`I2CSS_OFS_CTRL, 8'h00);
      rdchk(`I2CSS_OFS_STAT, `I2CSS_RST_CODE);
      rdchk(`I2CSS_OFS_DATA, 8'hFF);
      rdchk(4'h2, 8'h00);
      wb(1'b1, `I2CSS_OFS_ADDR, 8'h55);
      rdchk(`I2CSS_OFS_ADDR, 8'h55);
      clr(8'h44);
      rdchk(`I2CSS_OFS_CTRL, 8'h44);
   endtask
   task automatic t_own_write;
      m_u.start;
      send(8'h54, 1'b0);
      flag(`I2CSS_SC_SRW);
      clr(8'hC4);
      send(8'h3C, 1'b0);
      flag(`I2CSS_SC_RXACK);
      clr(8'hE4);
      m_u.stop;
      flag(`I2CSS_SC_STOP);
      clr(8'hC4);
      `CHK(n_start, 1)
      rdchk(`I2CSS_OFS_DATA, 8'h3C);
   endtask
   task automatic t_fifo;
      m_u.start;
      send(8'h54, 1'b0);
      flag(`I2CSS_SC_SRW);
      clr(8'hC4);
      for (int k = 0; k < 8; k++) begin
         send(8'h10 + 8'(k), 1'b0);
         flag(`I2CSS_SC_RXACK);
         clr(8'hC4);
      end
      fork
         send(8'h20, 1'b0);
         begin
            repeat (150) @(posedge core_clk);
            `CHK(scl_oe_n, 1'b0)
            rdchk(`I2CSS_OFS_DATA, 8'h10);
         end
      join
      flag(`I2CSS_SC_RXACK);
      clr(8'hC4);
      m_u.stop;
      flag(`I2CSS_SC_STOP);
      clr(8'hC4);
      for (int k = 1; k < 9; k++) rdchk(`I2CSS_OFS_DATA, (k < 8) ? 8'h10 + 8'(k) : 8'h20);
      rdchk(`I2CSS_OFS_DATA, 8'hFF);
   endtask
   task automatic t_gc;
      m_u.start;
      send(8'h56, 1'b1);
      m_u.stop;
      m_u.start;
      send(8'h00, 1'b0);
      flag(`I2CSS_SC_GCW);
      clr(8'hC4);
      send(8'h11, 1'b0);
      flag(`I2CSS_SC_GCACK);
      clr(8'h84);
      send(8'h22, 1'b1);
      flag(`I2CSS_SC_GCNAK);
      clr(8'hC4);
      m_u.stop;
      rdchk(`I2CSS_OFS_CTRL, 8'h44);
      rdchk(`I2CSS_OFS_DATA, 8'h11);
      wb(1'b1, `I2CSS_OFS_ADDR, 8'h54);
      m_u.start;
      send(8'h00, 1'b1);
      m_u.stop;
      wb(1'b1, `I2CSS_OFS_ADDR, 8'h55);
   endtask
   task automatic t_read;
      m_u.start;
      send(8'h55, 1'b0);
      flag(`I2CSS_SC_SRR);
      wb(1'b1, `I2CSS_OFS_DATA, 8'hA5);
      clr(8'hC4);
      m_u.xfer(9'h1FE, rx);
      `CHK(rx[8:1], 8'hA5)
      flag(`I2CSS_SC_TXACK);
      wb(1'b1, `I2CSS_OFS_DATA, 8'h5A);
      clr(8'h84);
      m_u.xfer(9'h1FE, rx);
      `CHK(rx[8:1], 8'h5A)
      flag(`I2CSS_SC_TXLST);
      clr(8'hC4);
      m_u.xfer(9'h1FE, rx);
      `CHK(rx[8:1], 8'hFF)
      m_u.stop;
      rdchk(`I2CSS_OFS_CTRL, 8'h44);
   endtask
   task automatic t_arb;
      arb_lost <= 1'b1;
      m_u.start;
      send(8'h55, 1'b0);
      flag(`I2CSS_SC_ARBR);
      arb_lost <= 1'b0;
      wb(1'b1, `I2CSS_OFS_DATA, 8'hC3);
      clr(8'hC4);
      m_u.xfer(9'h1FF, rx);
      `CHK(rx[8:1], 8'hC3)
      flag(`I2CSS_SC_TXNAK);
      clr(8'hC4);
      m_u.stop;
      arb_lost <= 1'b1;
      m_u.start;
      send(8'h54, 1'b0);
      flag(`I2CSS_SC_ARBW);
      clr(8'hC4);
      m_u.stop;
      flag(`I2CSS_SC_STOP);
      clr(8'hC4);
      m_u.start;
      send(8'h00, 1'b0);
      flag(`I2CSS_SC_ARBGC);
      clr(8'hC4);
      m_u.stop;
      flag(`I2CSS_SC_STOP);
      clr(8'hC4);
      arb_lost <= 1'b0;
   endtask
   task automatic t_acken_sleep;
      clr(8'h04);
      m_u.start;
      send(8'h54, 1'b1);
      m_u.stop;
      clr(8'h44);
      deep_sleep <= 1'b1;
      m_u.start;
      send(8'h54, 1'b0);
      repeat (40) @(posedge core_clk);
      `CHK(scl_oe_n, 1'b0)
      `CHK(n_wake, 1)
      deep_sleep <= 1'b0;
      flag(`I2CSS_SC_SRW);
      clr(8'hC4);
      repeat (3) @(posedge core_clk);
      `CHK(scl_oe_n, 1'b1)
      m_u.stop;
      flag(`I2CSS_SC_STOP);
      clr(8'hC4);
   endtask
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      wdat = 32'h00000000;
      deep_sleep = 1'b0;
      arb_lost = 1'b0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      t_reset;
      t_own_write;
      t_fifo;
      t_gc;
      t_read;
      t_arb;
      t_acken_sleep;
      close_out;
   end
endmodule // tb_i2c_slave_mode_engine
